// file: src/rxs_defs.vh
// Purpose: constants for the receive status word and receiver control block
// Assumes: 32-bit classic Wishbone register bus, 200 MHz system clock
// Notes:   offsets are byte addresses of aligned words
`ifndef RXS_DEFS_VH
`define RXS_DEFS_VH

// Register offsets
`define RXS_MAC_CTRL_ADDR   8'h00
`define RXS_RX_STAT_ADDR    8'h04
`define RXS_STATUS_ADDR     8'h08
`define RXS_INFO_ADDR       8'h0C

// Control register fields
`define RXS_CTRL_RECEIVE_ENABLE_BIT_BIT   0
`define RXS_CTRL_PASSBAD    16
`define RXS_CTRL_RESET      32'h00000000

// Status word field positions
`define RXS_SW_FILT_FAIL    30
`define RXS_SW_LEN_HI       29
`define RXS_SW_LEN_LO       16
`define RXS_SW_ES           15
`define RXS_SW_BCAST        13
`define RXS_SW_LEN_ERR      12
`define RXS_SW_RUNT         11
`define RXS_SW_MCAST        10
`define RXS_SW_TOO_LONG     7
`define RXS_SW_LATE_COL     6
`define RXS_SW_FTYPE        5
`define RXS_SW_WDOG         4
`define RXS_SW_MII_ERR      3
`define RXS_SW_DRIBBLE      2
`define RXS_SW_CRC_ERR      1

// Frame length limits in bytes
`define RXS_COL_WINDOW      14'h0040
`define RXS_MAX_FRAME       14'h05EE
`define RXS_MAX_LENFIELD    16'h05DC
`define RXS_HDR_BYTES       14'h000E
`define RXS_WDOG_BYTES      14'h0800

// Status FIFO depth
`define RXS_SFIFO_DEPTH     16
`define RXS_SFIFO_AW        4

`endif

// file: src/rxs_status_ctrl.v
// Purpose: builds per-frame receive status words, queues them for the host,
//          and handles receiver stop/start and receiver error flagging
// Assumes: frame summary arrives from the receive front end in one cycle
// Notes:   data FIFO storage lives elsewhere; its underrun arrives as a pulse
//
// Contract
// - Status bit 31 and bits 14, 9, 8, 0 always read zero.
// - Bit 30 set when frame failed destination address filter.
// - Bits 29:16 hold frame byte count.
// - Bit 15 is OR of bits 11, 7, 6 and 1.
// - Bit 13 set for broadcast destination.
// - Bit 12 set when length field disagrees with actual length.
// - Bit 11 flags frame ending before 64 bytes.
// - Runts reach host only when pass-bad-frames bit 16 is set.
// - Bit 10 set for multicast destination.
// - Bit 7 set above 1518 bytes; frame kept whole.
// - Bit 6 flags collision after the collision window.
// - Bit 5 set when type field exceeds 1500; never for runts under 14.
// - Bit 4 set when receive watchdog expires on overlong frame.
// - Bit 3 set if RX_ER seen during reception.
// - Bit 2 flags non-byte-multiple frames per mode threshold.
// - Dribble bit suppressed when late collision set.
// - Bit 1 set on CRC mismatch or RX_ER during reception.
// - CRC error bit meaningless for runts, late collision, watchdog.
// - One stopped pulse once the receiver has actually halted.
// - Error flag on data underrun, status underrun, status overrun.
// - Error flag does not stop the receiver.
// - Status word pushed after the frame data, as final item.
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "rxs_defs.vh"

module rxs_status_ctrl (
    input  wire        clk_i,          // System clock, 200 MHz
    input  wire        rst_i,          // Synchronous reset, active high
    input  wire        ce_i,           // Clock enable, freezes all state
    // Wishbone slave
    input  wire        wb_cyc_i,       // Bus cycle
    input  wire        wb_stb_i,       // Strobe
    input  wire        wb_we_i,        // Write enable
    input  wire [7:0]  wb_adr_i,       // Byte address
    input  wire [3:0]  wb_sel_i,       // Byte selects
    input  wire [31:0] wb_dat_i,       // Write data
    output reg  [31:0] wb_dat_o,       // Read data
    output reg         wb_ack_o,       // Acknowledge
    // Receive front end
    input  wire        rx_frame_act_i, // Frame reception in progress
    input  wire        rx_er_i,        // PHY receive error
    input  wire        rx_col_i,       // Collision indication
    input  wire        rx_byte_i,      // One byte received this cycle
    input  wire        rx_end_i,       // Frame end pulse, summary valid
    input  wire        rx_filt_fail_i, // Address filter failed
    input  wire        rx_bcast_i,     // Broadcast destination
    input  wire        rx_mcast_i,     // Multicast destination
    input  wire [15:0] rx_lentype_i,   // Length/type field value
    input  wire        rx_crc_bad_i,   // CRC mismatch
    input  wire [2:0]  rx_extra_bits_i,// Bits beyond last whole byte
    input  wire        rx_nibble_i,    // Nibble (MII) mode, else 10 Mbps
    input  wire        rx_data_done_i, // Frame data fully written
    input  wire        dfifo_unf_i,    // Host underrun of data FIFO
    output reg         rx_enabled_o,   // Receiver accepting frames
    output reg         rx_stop_evt_o,  // Receiver stopped pulse
    output reg         rx_err_o        // Receiver error flag
);

    // ------------------------------------------------------------------
    // Control and flags
    // ------------------------------------------------------------------
    reg  [31:0] mac_ctrl;
    reg  [13:0] byte_cnt;
    reg         seen_er;
    reg         seen_late_col;
    reg         pend_valid;
    reg  [31:0] pend_word;
    reg  [31:0] sfifo [0:`RXS_SFIFO_DEPTH-1];
    reg  [`RXS_SFIFO_AW:0] wr_ptr;
    reg  [`RXS_SFIFO_AW:0] rd_ptr;
    reg  [31:0] next_word;
    reg         keep_frame;

    wire receive_enable_bit = mac_ctrl[`RXS_CTRL_RECEIVE_ENABLE_BIT_BIT];
    wire pass_bad = mac_ctrl[`RXS_CTRL_PASSBAD];
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire sf_empty = (wr_ptr == rd_ptr);
    wire sf_full = (wr_ptr[`RXS_SFIFO_AW] != rd_ptr[`RXS_SFIFO_AW]) &&
                   (wr_ptr[`RXS_SFIFO_AW-1:0] == rd_ptr[`RXS_SFIFO_AW-1:0]);
    wire [`RXS_SFIFO_AW:0] sf_level = wr_ptr - rd_ptr;
    wire sf_read = bus_req & ~wb_we_i & (wb_adr_i == `RXS_RX_STAT_ADDR);

    // Byte-lane merge for writes
    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  sel;
        integer k;
        begin
            merge = old_v;
            for (k = 0; k < 4; k = k + 1) begin
                if (sel[k]) begin
                    merge[8*k +: 8] = new_v[8*k +: 8];
                end
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // Status word assembly
    // ------------------------------------------------------------------
    always @* begin
        next_word = 32'h00000000;
        next_word[`RXS_SW_FILT_FAIL] = rx_filt_fail_i;
        next_word[`RXS_SW_LEN_HI:`RXS_SW_LEN_LO] = byte_cnt;
        next_word[`RXS_SW_BCAST] = rx_bcast_i;
        next_word[`RXS_SW_MCAST] = rx_mcast_i;
        next_word[`RXS_SW_RUNT] = (byte_cnt < `RXS_COL_WINDOW);
        // too long, still counted in full
        next_word[`RXS_SW_TOO_LONG] = (byte_cnt > `RXS_MAX_FRAME);
        next_word[`RXS_SW_LATE_COL] = seen_late_col;
        // frame type, never for short runts
        next_word[`RXS_SW_FTYPE] = (byte_cnt >= `RXS_HDR_BYTES) &&
                                   (rx_lentype_i > `RXS_MAX_LENFIELD);
        // length mismatch for length-encoded frames only
        next_word[`RXS_SW_LEN_ERR] = (byte_cnt >= `RXS_HDR_BYTES) &&
            (rx_lentype_i <= `RXS_MAX_LENFIELD) &&
            ({2'b00, byte_cnt} != rx_lentype_i + 16'h0012);
        next_word[`RXS_SW_WDOG] = (byte_cnt > `RXS_WDOG_BYTES);
        next_word[`RXS_SW_MII_ERR] = seen_er;
        // dribble threshold, suppressed by late collision
        next_word[`RXS_SW_DRIBBLE] = ~seen_late_col &&
            (rx_nibble_i ? (rx_extra_bits_i == 3'h4)
                         : (rx_extra_bits_i >= 3'h3));
        // CRC or PHY error; undefined meaning for bad frames
        next_word[`RXS_SW_CRC_ERR] = rx_crc_bad_i | seen_er;
        next_word[`RXS_SW_ES] = next_word[`RXS_SW_RUNT] |
            next_word[`RXS_SW_TOO_LONG] | next_word[`RXS_SW_LATE_COL] |
            next_word[`RXS_SW_CRC_ERR];
        next_word[31] = 1'b0;
        next_word[14] = 1'b0;
        next_word[9] = 1'b0;
        next_word[8] = 1'b0;
        next_word[0] = 1'b0;
        keep_frame = ~next_word[`RXS_SW_RUNT] | pass_bad;
    end

    // ------------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------------
    // Write strobe for one register; reads never alter control state
    function wr_hit;
        input       req;
        input       we;
        input [7:0] adr;
        input [7:0] target;
        begin
            wr_hit = req & we & (adr == target);
        end
    endfunction

    wire ctrl_wr   = wr_hit(bus_req, wb_we_i, wb_adr_i,
                            `RXS_MAC_CTRL_ADDR);
    wire stat_wr   = wr_hit(bus_req, wb_we_i, wb_adr_i,
                            `RXS_STATUS_ADDR);
    wire rd_req    = bus_req & ~wb_we_i;
    // Clear request for the sticky error flag, byte lane 0 only
    wire err_clr   = stat_wr & wb_sel_i[0] & wb_dat_i[0];

    // ------------------------------------------------------------------
    // Frame events
    // ------------------------------------------------------------------
    // Frames that start while the receiver is off are ignored whole
    wire frame_live  = rx_enabled_o & rx_frame_act_i;
    wire frame_end   = rx_enabled_o & rx_end_i;
    wire sf_push     = pend_valid & rx_data_done_i;
    wire sf_overrun  = sf_push & sf_full;
    wire sf_underrun = sf_read & sf_empty;
    // Enable changes are taken only here, so no frame is cut in two
    wire idle_point  = ~rx_frame_act_i & ~pend_valid;

    // ------------------------------------------------------------------
    // Bus acknowledge
    // ------------------------------------------------------------------
    // One cycle answer; bus_req masks the cycle after an ack, so a
    // held strobe never earns a second acknowledge for one request
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= bus_req;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            mac_ctrl <= `RXS_CTRL_RESET;
        end else if (ce_i) begin
            // host stop and resume via enable
            if (ctrl_wr) begin
                mac_ctrl <= merge(mac_ctrl, wb_dat_i, wb_sel_i) &
                            32'h00010001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Receiver enable and stopped event
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_enabled_o  <= 1'b0;
            rx_stop_evt_o <= 1'b0;
        end else if (ce_i) begin
            rx_stop_evt_o <= 1'b0;
            // Receiver halts only between frames
            if (idle_point) begin
                if (rx_enabled_o && !receive_enable_bit) begin
                    rx_stop_evt_o <= 1'b1;
                end
                rx_enabled_o <= receive_enable_bit;
            end
        end
    end

    // ------------------------------------------------------------------
    // Per-frame accumulation
    // ------------------------------------------------------------------
    // The count saturates rather than wraps, so a runaway frame can
    // never fold back into a legal length
    always @(posedge clk_i) begin
        if (rst_i) begin
            byte_cnt      <= 14'h0000;
            seen_er       <= 1'b0;
            seen_late_col <= 1'b0;
        end else if (ce_i) begin
            if (frame_end) begin
                byte_cnt      <= 14'h0000;
                seen_er       <= 1'b0;
                seen_late_col <= 1'b0;
            end else if (frame_live) begin
                if (rx_byte_i && byte_cnt != 14'h3FFF) begin
                    byte_cnt <= byte_cnt + 14'h0001;
                end
                if (rx_er_i) begin
                    seen_er <= 1'b1;
                end
                if (rx_col_i && byte_cnt >= `RXS_COL_WINDOW) begin
                    seen_late_col <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Pending status word
    // ------------------------------------------------------------------
    // A new frame end beats the push of the older word, so its status
    // is held rather than lost when both land in one cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            pend_valid <= 1'b0;
            pend_word  <= 32'h00000000;
        end else if (ce_i) begin
            if (frame_end && keep_frame) begin
                pend_valid <= 1'b1;
                pend_word  <= next_word;
            end else if (sf_push) begin
                pend_valid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status queue
    // ------------------------------------------------------------------
    // status pushed only after data is written
    always @(posedge clk_i) begin
        if (!rst_i && ce_i && sf_push && !sf_full) begin
            sfifo[wr_ptr[`RXS_SFIFO_AW-1:0]] <= pend_word;
        end
    end

    // Extra pointer bit tells a full queue from an empty one
    always @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= 5'h00;
            rd_ptr <= 5'h00;
        end else if (ce_i) begin
            if (sf_push && !sf_full) begin
                wr_ptr <= wr_ptr + 5'h01;
            end
            if (sf_read && !sf_empty) begin
                rd_ptr <= rd_ptr + 5'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Receiver error flag
    // ------------------------------------------------------------------
    // Overrun drops the word: the host clears the flag by writing bit 0 at the status offset
    wire err_set = sf_overrun | dfifo_unf_i | sf_underrun;

    // error flag, reception continues; set wins
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_err_o <= 1'b0;
        end else if (ce_i) begin
            if (err_set) begin
                rx_err_o <= 1'b1;
            end else if (err_clr) begin
                rx_err_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Read data is registered and held until the next read
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (ce_i && rd_req) begin
            case (wb_adr_i)
                `RXS_MAC_CTRL_ADDR: begin
                    wb_dat_o <= mac_ctrl;
                end
                `RXS_RX_STAT_ADDR: begin
                    wb_dat_o <= sf_empty ? 32'h00000000 :
                                sfifo[rd_ptr[`RXS_SFIFO_AW-1:0]];
                end
                `RXS_STATUS_ADDR: begin
                    wb_dat_o <= {30'h00000000, rx_enabled_o, rx_err_o};
                end
                `RXS_INFO_ADDR: begin
                    wb_dat_o <= {27'h0000000, sf_level};
                end
                default: begin
                    wb_dat_o <= 32'h00000000;
                end
            endcase
        end
    end

endmodule // rxs_status_ctrl

// file: sim/rxs_status_ctrl_assertions.sv
// Purpose: port checks for rxs_status_ctrl
// Assumes: clock enable held high
// Notes:   status reads are judged on their ack cycle
`timescale 1ns/1ps
module rxs_status_ctrl_assertions (
    input wire        clk_i,         // Clock
    input wire        rst_i,         // Reset
    input wire        ce_i,          // Clock enable
    input wire        wb_cyc_i,      // Cycle
    input wire        wb_stb_i,      // Strobe
    input wire        wb_we_i,       // Write
    input wire [7:0]  wb_adr_i,      // Address
    input wire [31:0] wb_dat_o,      // Read data
    input wire        wb_ack_o,      // Ack
    input wire        rx_enabled_o,  // Receiver live
    input wire        rx_stop_evt_o, // Stopped pulse
    input wire        rx_err_o       // Error flag
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire req = wb_cyc_i && wb_stb_i;
    reg       last_we;
    reg [7:0] last_adr;
    always @(posedge clk_i) begin
        last_we  <= wb_we_i;
        last_adr <= wb_adr_i;
    end
    wire srd = wb_ack_o && !last_we && last_adr == 8'h04;
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack wider than one cycle");
    a_ack_latency: assert property (req && !wb_ack_o && ce_i |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_cause: assert property (!req |=> !wb_ack_o)
        else $error("ack without request");
    a_stat_reserved: assert property (
        srd |-> (wb_dat_o & 32'h80004301) == 32'h0)
        else $error("reserved status bit set");
    a_stat_summary: assert property (
        srd |-> wb_dat_o[15] == (wb_dat_o[11] | wb_dat_o[7] | wb_dat_o[6]
                                 | wb_dat_o[1]))
        else $error("summary error bit wrong");
    a_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i)
        && $past(wb_adr_i) > 8'h0C |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_stop_single: assert property (rx_stop_evt_o |=> !rx_stop_evt_o)
        else $error("stop pulse too long");
    a_stop_halt: assert property (
        1'b1 |-> rx_stop_evt_o == $fell(rx_enabled_o))
        else $error("stop pulse not with halt");
    a_err_sticky: assert property (rx_err_o && !(req && wb_we_i
        && wb_adr_i == 8'h08) |=> rx_err_o)
        else $error("error flag dropped alone");
    a_err_no_stop: assert property ($rose(rx_err_o) |-> !rx_stop_evt_o)
        else $error("error stopped receiver");
endmodule // rxs_status_ctrl_assertions

// file: sim/rxs_front_model.sv
// Purpose: receive front end feeding frames to the status block
// Assumes: one byte pulse per cycle
// Notes:   summary lines carry inverted junk outside their valid cycle
`timescale 1ns/1ps
module rxs_front_model (
    input  wire        clk_i, // Clock
    output reg         act_o, // Frame active
    output reg         er_o,  // PHY error
    output reg         col_o, // Collision
    output reg         byt_o, // Byte pulse
    output reg         end_o, // Frame end
    output reg  [4:0]  f_o,   // nibble,crc,mcast,bcast,filt
    output reg  [15:0] lt_o,  // Length/type
    output reg  [2:0]  xb_o,  // Extra bits
    output reg         dn_o   // Data written
);
    initial {act_o, er_o, col_o, byt_o, end_o, f_o, lt_o, xb_o, dn_o} = 0;
    task automatic send(input int n, input [15:0] lt, input [5:0] f,
                        input [2:0] xb, input int c);
        int i;
        @(posedge clk_i); act_o <= 1'b1;
        er_o <= f[5];
        for (i = 0; i < n; i++) begin
            @(posedge clk_i); byt_o <= 1'b1; col_o <= (i == c);
        end
        @(posedge clk_i); byt_o <= 0; col_o <= 0; er_o <= 0; end_o <= 1;
        f_o <= f[4:0]; lt_o <= lt; xb_o <= xb;
        @(posedge clk_i); end_o <= 0; act_o <= 0; dn_o <= 1;
        f_o <= ~f[4:0]; lt_o <= ~lt; xb_o <= ~xb;
        @(posedge clk_i); dn_o <= 0;
    endtask
endmodule // rxs_front_model

// file: sim/rxs_status_ctrl_bench.sv
// Purpose: self-checking bench for rxs_status_ctrl
// Assumes: one clock at 200 MHz, seed 57
// Notes:   expected status words come from sw() below
`timescale 1ns/1ps
module rxs_status_ctrl_bench;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, unf = 0;
    logic [7:0] adr = 0; logic [31:0] wd = 0, rd; logic [31:0] q[$];
    wire [31:0] dat; wire ack, en, stp, err, act, er, col, byt, fin, dn;
    wire [4:0] f5; wire [15:0] lt; wire [2:0] xb;
    int fails = 0, checks_done = 0, seed = 57, i, n, k;
    int tab[6] = '{13, 14, 63, 64, 1519, 2049};
    logic [5:0] f; logic [2:0] x; logic [15:0] lv;
    always #2.5 clk_i = ~clk_i;
    rxs_front_model fm (.clk_i(clk_i), .act_o(act), .er_o(er), .col_o(col),
        .byt_o(byt), .end_o(fin), .f_o(f5), .lt_o(lt), .xb_o(xb), .dn_o(dn));
    rxs_status_ctrl rxs_status_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(dat),
        .wb_ack_o(ack), .rx_frame_act_i(act), .rx_er_i(er), .rx_col_i(col),
        .rx_byte_i(byt), .rx_end_i(fin), .rx_filt_fail_i(f5[0]),
        .rx_bcast_i(f5[1]), .rx_mcast_i(f5[2]), .rx_lentype_i(lt),
        .rx_crc_bad_i(f5[3]), .rx_extra_bits_i(xb), .rx_nibble_i(f5[4]),
        .rx_data_done_i(dn), .dfifo_unf_i(unf), .rx_enabled_o(en),
        .rx_stop_evt_o(stp), .rx_err_o(err));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            fails++; $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task end_sim;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic bus(input logic w, input [7:0] a, input [31:0] d);
        @(posedge clk_i); cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d;
        for (k = 0; k < 20 && ack !== 1'b1; k++) @(posedge clk_i);
        if (k == 20) begin fails++; end_sim; end
        rd = dat; cyc <= 0; stb <= 0; we <= 0;
    endtask
    function automatic logic [31:0] sw(int n, logic [15:0] lt,
                                       logic [5:0] f, logic [2:0] x, int c);
        logic rn, tl, lc, cr, dr; logic [13:0] l;
        l = n; rn = n < 64; tl = n > 1518; lc = c >= 64 && c < n;
        cr = f[3] | f[5]; dr = !lc && (f[4] ? x == 3'h4 : x >= 3'h3);
        return {1'b0, f[0], l, rn | tl | lc | cr, 1'b0, f[1],
                n >= 14 && lt <= 16'd1500 && n != lt + 18, rn, f[2],
                2'b00, tl, lc,
                lt > 16'd1500 && n >= 14, n > 2048, f[5], dr, cr, 1'b0};
    endfunction
    task automatic frame(input int n, input int c);
        fm.send(n, lv, f, x, c); q.push_back(sw(n, lv, f, x, c));
        repeat (3) @(posedge clk_i);
    endtask
    initial begin
        repeat (16) @(posedge clk_i); rst_i <= 0;
        bus(0, 8'h00, 0); chk(rd, 32'h0);
        bus(0, 8'h10, 0); chk(rd, 32'h0);
        bus(1, 8'h00, 32'h00010001); // enable, pass bad frames
        for (i = 0; i < 24; i++) begin
            n = i < 6 ? tab[i] : 10 + $unsigned($random(seed)) % 2100;
            f = $random(seed); x = $random(seed);
            lv = f[0] ? 16'h0800 : (i[1] ? n - 18 : 16'd46);
            frame(n, i % 3 == 0 ? 100 : (i % 3 == 1 ? 10 : -1));
            bus(0, 8'h0C, 0); chk(rd, 32'h1);
            bus(0, 8'h04, 0); chk(rd, q.pop_front());
        end
        f = 0; x = 0; lv = 16'd46; bus(1, 8'h00, 32'h1);
        frame(20, -1); void'(q.pop_back()); frame(64, -1);
        bus(0, 8'h0C, 0); chk(rd, 32'h1);
        bus(0, 8'h04, 0); chk(rd, q.pop_front());
        bus(0, 8'h04, 0); chk(rd, 32'h0);
        repeat (2) @(posedge clk_i); chk(err, 1'b1);
        chk(en, 1'b1);
        bus(1, 8'h08, 32'h1); repeat (2) @(posedge clk_i); chk(err, 1'b0);
        @(posedge clk_i); unf <= 1; @(posedge clk_i); unf <= 0;
        repeat (2) @(posedge clk_i); chk(err, 1'b1);
        rst_i <= 1; repeat (2) @(posedge clk_i); rst_i <= 0;
        chk(err, 1'b0);
        bus(1, 8'h00, 32'h1);
        for (i = 0; i < 17; i++) frame(70, -1);
        bus(0, 8'h0C, 0); chk(rd, 32'h10);
        chk(err, 1'b1);
        for (i = 0; i < 16; i++) begin
            bus(0, 8'h04, 0); chk(rd, q.pop_front());
        end
        bus(1, 8'h00, 32'h0); // stop request
        for (k = 0; k < 50 && stp !== 1'b1; k++) @(posedge clk_i);
        chk(k < 50, 1'b1);
        repeat (2) @(posedge clk_i); chk(en, 1'b0);
        end_sim;
    end
endmodule // rxs_status_ctrl_bench
bind rxs_status_ctrl rxs_status_ctrl_assertions chk_inst (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_enabled_o(rx_enabled_o),
    .rx_stop_evt_o(rx_stop_evt_o), .rx_err_o(rx_err_o));
